// *** adcs_analog_model.sv ***
// Analog input stand-in: channel-tagged sample while busy, toggling when idle
module adcs_analog_model (
    input  logic       sys_clk,    // Clock
    input  logic [3:0] muxSel,     // Input
    input  logic       convActive, // Busy
    input  logic [5:0] salt,       // Low bits
    output logic [9:0] convResult  // Sample
);
    timeunit 1ns;
    timeprecision 100ps;
    initial convResult = 10'h000;
    always @(posedge sys_clk) convResult <= convActive ? {muxSel, salt} : ~convResult;
endmodule

// *** adcs_consts.vh ***
// Constants for the converter control and status block
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH

// ==========================================
// Control/status register fields
`define ADCS_BIT_FLAG      7
`define ADCS_BIT_IRQEN     6
`define ADCS_BIT_RUN       5
`define ADCS_BIT_SCAN      4
`define ADCS_CHAN_MSB      3
`define ADCS_CHAN_LSB      0
`define ADCS_CSR_RESET     8'h00

// ==========================================
// Modes and timing
`define ADCS_MODE_SINGLE   1'h0
`define ADCS_MODE_SCAN     1'h1
`define ADCS_CONV_TIME_NS  11080
`define ADCS_CLK_PERIOD_NS 25
`define ADCS_CONV_CYCLES   ((`ADCS_CONV_TIME_NS) / (`ADCS_CLK_PERIOD_NS))
`define ADCS_CNT_W         10
`define ADCS_RESULT_RESET  10'h000

`endif

// *** adcs_control_status.v ***
// Converter control/status register and single/scan conversion sequencer
// How it works
// RL1 - Single mode: flag set when channel done
// RL2 - Scan mode: flag set after whole group
// RL3 - Flag clears by zero-write after reading one
// RL4 - Interrupt only while enable set; resets zero
// RL5 - Writing run zero stops, returns idle
// RL6 - Writing run one starts; reads one meanwhile
// RL7 - Single mode: run self-clears when done
// RL8 - Scan continues until run cleared
// RL9 - Mode bit: zero single, one scan
// RL10 - Single mode: channel field picks input
// RL11 - Scan: group upper bits, offsets zero..k
// RL12 - Scan results stored per group position
// RL13 - Scan restarts at group's first channel
// RL14 - Software stops before changing mode/channel
// RL15 - Interrupt held while flag and enable
module adcs_control_status (
    input  wire        sys_clk,      // System clock, 40 MHz
    input  wire        rst_n,        // Asynchronous reset, active low
    input  wire        csrWrite,     // Register write strobe, one cycle
    input  wire        csrRead,      // Register read strobe, one cycle
    input  wire [7:0]  csrWdata,     // Write data
    input  wire        standby,      // Standby or module stop, level
    input  wire [9:0]  convResult,   // Result from analog core
    output reg  [7:0]  csrRdata,     // Register read data
    output reg         conversion_end_irq, // End-of-conversion request
    output reg  [3:0]  muxSel,       // Analog input being converted
    output reg         convActive,   // Analog core converting
    output reg  [9:0]  resultA,      // Result of group offset 0
    output reg  [9:0]  resultB,      // Result of group offset 1
    output reg  [9:0]  resultC,      // Result of group offset 2
    output reg  [9:0]  resultD       // Result of group offset 3
);
`include "adcs_consts.vh"

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    // ==========================================
    // Register fields and sequencer state
    reg        conversion_end_flag;
    reg        end_irq_enable;
    reg        conversion_run;
    reg        scanMode;
    reg [3:0]  chanSel;
    reg        flagSeenSet;
    reg        state;
    reg [1:0]  offset;
    wire       convDone;

    // ==========================================
    // Next values
    reg        next_state;
    reg        next_run;
    reg [1:0]  next_offset;
    reg        next_flag;
    reg        next_seen;

    // ==========================================
    // Decoded strobes and conditions
    wire [1:0] lastOffset  = chanSel[1:0];
    wire       lastInGroup = (scanMode == `ADCS_MODE_SINGLE) || (offset == lastOffset);
    wire       writeStop   = csrWrite && !csrWdata[`ADCS_BIT_RUN];
    wire       writeStart  = csrWrite && csrWdata[`ADCS_BIT_RUN];
    wire       flagClear   = csrWrite && !csrWdata[`ADCS_BIT_FLAG] && flagSeenSet;
    wire       stopNow     = writeStop || standby;
    wire       groupEnd    = (state == ST_CONV) && convDone && lastInGroup;
    wire       storeNow    = (state == ST_CONV) && convDone && !stopNow;
    wire [3:0] slotOneHot  = 4'h1 << offset;
    wire [3:0] storeHit;
    wire [7:0] csrImage    = {conversion_end_flag, end_irq_enable, conversion_run, scanMode, chanSel};

    // ==========================================
    // Timer
    adcs_conv_timer u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (writeStart || (state == ST_IDLE)),
        .enable  (state == ST_CONV),
        .done    (convDone)
    );

    // ==========================================
    // Control fields, loaded by every write
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            end_irq_enable <= 1'b0; // RL4
            scanMode       <= `ADCS_MODE_SINGLE; // RL9
            chanSel        <= 4'h0;
        end else if (csrWrite) begin
            end_irq_enable <= csrWdata[`ADCS_BIT_IRQEN];
            scanMode       <= csrWdata[`ADCS_BIT_SCAN]; // RL9
            chanSel        <= csrWdata[`ADCS_CHAN_MSB:`ADCS_CHAN_LSB];
        end
    end

    // ==========================================
    // Sequencer next state
    always @* begin
        next_state  = state;
        next_run    = conversion_run;
        next_offset = offset;
        case (state)
            ST_IDLE: begin
                if (writeStart && !standby) begin
                    next_state  = ST_CONV;
                    next_run    = 1'b1; // RL6
                    next_offset = 2'h0;
                end
            end
            ST_CONV: begin
                if (stopNow) begin
                    next_state  = ST_IDLE;
                    next_run    = 1'b0; // RL5 RL8
                    next_offset = 2'h0;
                end else if (writeStart) begin
                    next_offset = 2'h0; // RL6
                end else if (convDone) begin
                    if (!lastInGroup) begin
                        next_offset = offset + 2'h1;
                    end else if (scanMode == `ADCS_MODE_SCAN) begin
                        next_offset = 2'h0; // RL13
                    end else begin
                        next_state = ST_IDLE;
                        next_run   = 1'b0; // RL7
                    end
                end
            end
            default: begin
                next_state  = ST_IDLE;
                next_run    = 1'b0;
                next_offset = 2'h0;
            end
        endcase
    end

    // ==========================================
    // Sequencer registers
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_run <= 1'b0;
            state          <= ST_IDLE;
            offset         <= 2'h0;
        end else begin
            conversion_run <= next_run;
            state          <= next_state;
            offset         <= next_offset;
        end
    end

    // ==========================================
    // End flag: set wins over clear
    always @* begin
        next_flag = conversion_end_flag;
        if (groupEnd) begin
            next_flag = 1'b1; // RL1 RL2
        end else if (flagClear) begin
            next_flag = 1'b0; // RL3
        end
    end

    // Clear is armed only by reading the flag as one
    always @* begin
        next_seen = flagSeenSet;
        if (csrRead && conversion_end_flag) begin
            next_seen = 1'b1;
        end else if (csrWrite || !conversion_end_flag) begin
            next_seen = 1'b0;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_end_flag <= 1'b0;
            flagSeenSet         <= 1'b0;
        end else begin
            conversion_end_flag <= next_flag;
            flagSeenSet         <= next_seen;
        end
    end

    // ==========================================
    // Result slots, one per group position
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_slot
            assign storeHit[g] = storeNow && slotOneHot[g]; // RL12
        end
    endgenerate

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            resultA <= `ADCS_RESULT_RESET;
            resultB <= `ADCS_RESULT_RESET;
            resultC <= `ADCS_RESULT_RESET;
            resultD <= `ADCS_RESULT_RESET;
        end else begin
            if (storeHit[0]) begin
                resultA <= convResult;
            end
            if (storeHit[1]) begin
                resultB <= convResult;
            end
            if (storeHit[2]) begin
                resultC <= convResult;
            end
            if (storeHit[3]) begin
                resultD <= convResult;
            end
        end
    end

    // ==========================================
    // Registered outputs
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            csrRdata           <= `ADCS_CSR_RESET;
            conversion_end_irq <= 1'b0;
            muxSel             <= 4'h0;
            convActive         <= 1'b0;
        end else begin
            csrRdata           <= csrImage;
            conversion_end_irq <= conversion_end_flag && end_irq_enable; // RL4 RL15
            if (scanMode == `ADCS_MODE_SINGLE) begin
                muxSel <= chanSel; // RL10
            end else begin
                muxSel <= {chanSel[3:2], offset}; // RL11
            end
            convActive         <= (state == ST_CONV);
        end
    end
endmodule

// *** adcs_control_status_tb_top.sv ***
// Self-checking bench for the control/status block
bind adcs_control_status adcs_cs_properties u_props (.*);
module adcs_control_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk = 0, rst_n = 0, csrWrite = 0, csrRead = 0, standby = 0;
    logic [7:0] csrWdata = 8'h00;
    logic [5:0] salt = 6'h00;
    logic [3:0] ch;
    logic [9:0] res [4];
    wire  [9:0] convResult, resultA, resultB, resultC, resultD;
    wire  [7:0] csrRdata;
    wire  [3:0] muxSel;
    wire        conversion_end_irq, convActive;
    integer     seed = 69152;
    int         err_count = 0, cmp_count = 0, n, k;
    always #12.5 sys_clk = ~sys_clk;
    always_comb res = '{resultA, resultB, resultC, resultD};
    adcs_control_status dut (.*);
    adcs_analog_model u_ana (.*);
    task automatic cyc(input int c); repeat (c) @(posedge sys_clk); #2; endtask
    task automatic wr(input logic [7:0] d); cyc(1); csrWrite = 1; csrWdata = d; cyc(1); csrWrite = 0; endtask
    task automatic rd; cyc(1); csrRead = 1; cyc(1); csrRead = 0; endtask
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hold;
        n = 0;
        while (csrRdata[7] !== 1'b1 && n < 2000) begin cyc(1); n++; end
        chk("span", 10'h001, {9'h0, n >= 443 * (k + 1) - 2 && n <= 449 * (k + 1)});
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        cyc(8);
        rst_n = 1;
        cyc(1);
        chk("csr", 10'h000, {2'h0, csrRdata});
        for (int i = 0; i < 6; i++) begin
            ch = 4'($random(seed));
            salt = 6'($random(seed));
            k = i[0] ? int'(ch[1:0]) : 0;
            wr(i[0] ? {4'h3, ch} : {4'h6, ch});
            hold;
            for (int j = 0; j <= k; j++) chk("res", {ch[3:2], i[0] ? j[1:0] : ch[1:0], salt}, res[j]);
            chk("csr", {2'h0, i[0] ? 4'hB : 4'hC, ch}, {2'h0, csrRdata});
            chk("irq", {9'h0, !i[0]}, {9'h0, conversion_end_irq});
            wr(i[0] ? {4'hB, ch} : {4'hC, ch});
            cyc(1);
            chk("keep", 10'h001, {9'h0, csrRdata[7]});
            rd;
            wr(i[0] ? {4'h3, ch} : {4'h4, ch});
            cyc(1);
            chk("clr", {2'h0, i[0] ? 4'h3 : 4'h4, ch}, {2'h0, csrRdata});
            chk("irq", 10'h000, {9'h0, conversion_end_irq});
            if (i[0]) begin
                hold;
                if (i[1]) standby = 1;
                else wr({4'h1, ch});
                cyc(3);
                chk("stop", 10'h000, {8'h0, csrRdata[5], convActive});
                standby = 0;
                rd;
                wr(8'h00);
            end
        end
        close_out;
    end
    initial begin
        cyc(40000);
        err_count++;
        close_out;
    end
endmodule

// *** adcs_conv_timer.v ***
// Conversion timer: counts one channel's conversion time, pulses on completion
module adcs_conv_timer (
    input  wire sys_clk,   // System clock
    input  wire rst_n,     // Asynchronous reset, active low
    input  wire clear,     // Restart count from zero
    input  wire enable,    // Count while high
    output reg  done       // One-cycle pulse when time elapses
);
`include "adcs_consts.vh"

    localparam integer           LAST_FULL = `ADCS_CONV_CYCLES - 1;
    localparam [`ADCS_CNT_W-1:0] LAST      = LAST_FULL[`ADCS_CNT_W-1:0];

    reg [`ADCS_CNT_W-1:0] count;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {`ADCS_CNT_W{1'b0}};
            done  <= 1'b0;
        end else if (clear || !enable) begin
            count <= {`ADCS_CNT_W{1'b0}};
            done  <= 1'b0;
        end else if (count == LAST) begin
            count <= {`ADCS_CNT_W{1'b0}};
            done  <= 1'b1;
        end else begin
            count <= count + 1'b1;
            done  <= 1'b0;
        end
    end
endmodule

// *** adcs_cs_properties.sv ***
// Port assertions for the control/status block
module adcs_cs_properties (
    input logic       sys_clk,            // Clock
    input logic       rst_n,              // Reset
    input logic       csrWrite,           // Write
    input logic [7:0] csrWdata,           // Wdata
    input logic [7:0] csrRdata,           // Rdata
    input logic       conversion_end_irq, // Irq
    input logic [3:0] muxSel,             // Input
    input logic       convActive          // Busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_off; ##2 !csrRdata[5] ##[0:2] !convActive; endsequence
    property p_go; csrWrite && csrWdata[5] |-> ##2 csrRdata[5]; endproperty
    property p_stop; csrWrite && !csrWdata[5] |-> s_off; endproperty
    property p_irq; conversion_end_irq == (csrRdata[7] && csrRdata[6]); endproperty
    property p_w1; csrRdata[7] && csrWrite && csrWdata[7] |-> ##2 csrRdata[7]; endproperty
    property p_one; $fell(convActive) && !csrRdata[4] |-> !csrRdata[5]; endproperty
    property p_sel; convActive && !csrRdata[4] |-> muxSel == csrRdata[3:0]; endproperty
    property p_grp; convActive && csrRdata[4] |-> muxSel[3:2] == csrRdata[3:2] && muxSel[1:0] <= csrRdata[1:0]; endproperty
    property p_top; $rose(csrRdata[7]) && csrRdata[5:4] == 2'h3 |-> ##[0:3] muxSel[1:0] == 2'h0; endproperty
    a_go: assert property (p_go) else $error("run not set");
    a_stop: assert property (p_stop) else $error("no stop");
    a_irq: assert property (p_irq) else $error("bad irq");
    a_w1: assert property (p_w1) else $error("flag lost");
    a_one: assert property (p_one) else $error("run kept");
    a_sel: assert property (p_sel) else $error("bad input");
    a_grp: assert property (p_grp) else $error("bad group");
    a_top: assert property (p_top) else $error("no restart");
endmodule
